// [rtl/gpcfg_pin.v]
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_regs.vh"
module gpcfg_pin (
  // configuration
  input wire [7:0] cfg,
  // alternate function sources
  input wire alt1_out,
  input wire alt2_out,
  // pad side, synchronised input
  input wire pad_in_sync,
  output reg pad_out,
  output reg pad_oe,
  // logic side
  output reg gpio_in_value,
  input wire gpio_out_value
);
  reg drive_val;
  reg is_out;
  always @* begin
    // polarity inversion between pad and register
    gpio_in_value = pad_in_sync ^ cfg[`GPCFG_BIT_POL];
    is_out = ~cfg[`GPCFG_BIT_DIR];
    case (cfg[`GPCFG_FN_HI:`GPCFG_FN_LO])
      `GPCFG_FN_ALT1: drive_val = alt1_out;
      `GPCFG_FN_ALT2: drive_val = alt2_out;
      // reserved code falls back to plain gpio
      default: drive_val = gpio_out_value ^ cfg[`GPCFG_BIT_POL];
    endcase
    if (cfg[`GPCFG_BIT_OD]) begin
      pad_out = 1'b0;
      pad_oe = is_out & ~drive_val;
    end else begin
      pad_out = drive_val;
      pad_oe = is_out;
    end
  end
endmodule
`default_nettype wire

// [rtl/gpcfg_regs.vh]
`ifndef GPCFG_REGS_VH
`define GPCFG_REGS_VH
// printed offsets 0x42/0x43 are not multiples of four: byte address = 4 * index
`define GPCFG_IDX_PIN53 8'h42
`define GPCFG_IDX_PIN54 8'h43
`define GPCFG_ADDR_PIN53 10'h108
`define GPCFG_ADDR_PIN54 10'h10C
`define GPCFG_BIT_DIR 0
`define GPCFG_BIT_POL 1
`define GPCFG_FN_HI 3
`define GPCFG_FN_LO 2
`define GPCFG_BIT_OD 7
`define GPCFG_FN_GPIO 2'h0
`define GPCFG_FN_ALT1 2'h1
`define GPCFG_FN_ALT2 2'h2
`define GPCFG_RST_PIN53 8'h00
`define GPCFG_RST_PIN54 8'h01
`define GPCFG_WMASK 8'h8F
`endif

// [rtl/gpcfg_top.v]
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_regs.vh"
module gpcfg_top (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // gpio data from/to software logic
  input wire pin53_gpio_out,
  input wire pin54_gpio_out,
  output reg pin53_gpio_in,
  output reg pin54_gpio_in,
  // alternate functions
  input wire serial_b_transmit_data,
  output reg serial_b_dataset_ready_n,
  output reg interrupt_line_seven,
  output reg interrupt_line_nine,
  input wire interrupt_line_seven_source,
  input wire interrupt_line_nine_source,
  // pads
  input wire pin53_pad_in,
  output reg pin53_pad_out,
  output reg pin53_pad_oe,
  input wire pin54_pad_in,
  output reg pin54_pad_out,
  output reg pin54_pad_oe
);
  reg [7:0] pin53_config_reg;
  reg [7:0] pin54_config_reg;
  reg wr_pend_reg;
  reg [9:0] addr_reg;
  reg [1:0] p53_sync_reg;
  reg [1:0] p54_sync_reg;
  wire p53_in;
  wire p54_in;
  wire p53_out;
  wire p53_oe;
  wire p54_out;
  wire p54_oe;
  wire take;
  wire [9:0] a_low;
  wire [7:0] wbyte;
  assign take = hsel & hready & htrans[1];
  assign a_low = haddr[9:0];
  // reserved bits 6:4 never stored
  assign wbyte = hwdata[7:0] & `GPCFG_WMASK;
  // two-flop pad synchronisers, second stage only is read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p53_sync_reg <= 2'h0;
      p54_sync_reg <= 2'h0;
    end else begin
      p53_sync_reg <= {p53_sync_reg[0], pin53_pad_in};
      p54_sync_reg <= {p54_sync_reg[0], pin54_pad_in};
    end
  end
  // zero-wait slave: write data lands one cycle after address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin53_config_reg <= `GPCFG_RST_PIN53;
      pin54_config_reg <= `GPCFG_RST_PIN54;
      wr_pend_reg <= 1'b0;
      addr_reg <= 10'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (wr_pend_reg) begin
        if (addr_reg == `GPCFG_ADDR_PIN53)
          pin53_config_reg <= wbyte;
        if (addr_reg == `GPCFG_ADDR_PIN54)
          pin54_config_reg <= wbyte;
      end
      if (hready) begin
        wr_pend_reg <= take & hwrite;
        addr_reg <= a_low;
      end
      if (take & ~hwrite) begin
        // unmapped reads return zero
        // forward a write landing this edge, else back-to-back read is stale
        if (a_low == `GPCFG_ADDR_PIN53)
          hrdata <= {24'h000000,
            (wr_pend_reg && addr_reg == `GPCFG_ADDR_PIN53) ? wbyte : pin53_config_reg};
        else if (a_low == `GPCFG_ADDR_PIN54)
          hrdata <= {24'h000000,
            (wr_pend_reg && addr_reg == `GPCFG_ADDR_PIN54) ? wbyte : pin54_config_reg};
        else
          hrdata <= 32'h00000000;
      end
    end
  end
  gpcfg_pin u_pin53 (
    .cfg(pin53_config_reg),
    .alt1_out(serial_b_transmit_data),
    .alt2_out(interrupt_line_seven_source),
    .pad_in_sync(p53_sync_reg[1]),
    .pad_out(p53_out),
    .pad_oe(p53_oe),
    .gpio_in_value(p53_in),
    .gpio_out_value(pin53_gpio_out)
  );
  // pin54 alternates are inputs to the device, so no drive source
  gpcfg_pin u_pin54 (
    .cfg(pin54_config_reg),
    .alt1_out(1'b1),
    .alt2_out(1'b1),
    .pad_in_sync(p54_sync_reg[1]),
    .pad_out(p54_out),
    .pad_oe(p54_oe),
    .gpio_in_value(p54_in),
    .gpio_out_value(pin54_gpio_out)
  );
  // registered outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin53_gpio_in <= 1'b0;
      pin54_gpio_in <= 1'b0;
      pin53_pad_out <= 1'b0;
      pin53_pad_oe <= 1'b0;
      pin54_pad_out <= 1'b0;
      pin54_pad_oe <= 1'b0;
      serial_b_dataset_ready_n <= 1'b1;
      interrupt_line_seven <= 1'b0;
      interrupt_line_nine <= 1'b0;
    end else begin
      pin53_gpio_in <= p53_in;
      pin54_gpio_in <= p54_in;
      pin53_pad_out <= p53_out;
      pin53_pad_oe <= p53_oe;
      pin54_pad_out <= p54_out;
      // alternate inputs on pin54 never drive the pad
      pin54_pad_oe <= p54_oe &
        (pin54_config_reg[`GPCFG_FN_HI:`GPCFG_FN_LO] == `GPCFG_FN_GPIO ||
         pin54_config_reg[`GPCFG_FN_HI:`GPCFG_FN_LO] == 2'h3);
      if (pin54_config_reg[`GPCFG_FN_HI:`GPCFG_FN_LO] == `GPCFG_FN_ALT1)
        serial_b_dataset_ready_n <= p54_in;
      else
        serial_b_dataset_ready_n <= 1'b1;
      // interrupts routed when their function is selected: line nine from the pad, line seven from its source
      if (pin54_config_reg[`GPCFG_FN_HI:`GPCFG_FN_LO] == `GPCFG_FN_ALT2)
        interrupt_line_nine <= p54_in;
      else
        interrupt_line_nine <= 1'b0;
      if (pin53_config_reg[`GPCFG_FN_HI:`GPCFG_FN_LO] == `GPCFG_FN_ALT2)
        interrupt_line_seven <= interrupt_line_seven_source;
      else
        interrupt_line_seven <= 1'b0;
    end
  end
  // interrupt_line_nine_source unused beyond documenting input routing
  wire unused_ok;
  assign unused_ok = interrupt_line_nine_source | hsize[0] | (|haddr[31:10]) | (|hwdata[31:8]);
endmodule
`default_nettype wire

// [rtl/unused_placeholder_none.v]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [testbench/gpcfg_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module gpcfg_chk (
  // bus
  input wire logic hclk, hresetn, hsel, hready, hwrite,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // pins
  input wire logic pin53_pad_out, pin53_pad_oe, serial_b_transmit_data,
  input wire logic pin54_pad_in, pin54_pad_oe, pin54_gpio_in, interrupt_line_nine
);
  logic wr;
  logic [9:0] a;
  logic [7:0] c53, c54;
  // shadow built from bus traffic, not from design internals
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr <= 1'b0;
      a <= 10'h000;
      c53 <= 8'h00;
      c54 <= 8'h01;
    end else begin
      wr <= hsel && hready && htrans[1] && hwrite;
      a <= haddr[9:0];
      if (wr && a == 10'h108) c53 <= hwdata[7:0];
      if (wr && a == 10'h10C) c54 <= hwdata[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // four quiet samples cover the three-edge input path
  sequence s_quiet;
    ($stable(pin54_pad_in) && $stable(c54))[*4];
  endsequence
  sequence s_rd(logic [9:0] adr);
    hsel && hready && htrans[1] && !hwrite && haddr[9:0] == adr;
  endsequence
  property p_dir;
    $past(c54[0]) && c54[0] |-> !pin54_pad_oe;
  endproperty
  a_dir: assert property (p_dir) else $error("pin54 driven as input");
  property p_pol;
    s_quiet |-> pin54_gpio_in == (pin54_pad_in ^ c54[1]);
  endproperty
  a_pol: assert property (p_pol) else $error("pin54 input value");
  property p_fn54;
    s_quiet |-> interrupt_line_nine == (c54[3:2] == 2'h2 && (pin54_pad_in ^ c54[1]));
  endproperty
  a_fn54: assert property (p_fn54) else $error("line nine value");
  property p_od;
    c53[7] && $past(c53[7]) && pin53_pad_oe |-> !pin53_pad_out;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_rst;
    s_rd(10'h10C) |=> hrdata == {24'h000000, c54 & 8'h8F};
  endproperty
  a_rst: assert property (p_rst) else $error("pin54 readback");
  property p_fn53;
    c53 == 8'h04 && $past(c53) == 8'h04 |->
      pin53_pad_oe && pin53_pad_out == $past(serial_b_transmit_data);
  endproperty
  a_fn53: assert property (p_fn53) else $error("pin53 transmit");
  property p_rsv;
    s_rd(10'h108) |=> hrdata == {24'h000000, c53 & 8'h8F};
  endproperty
  a_rsv: assert property (p_rsv) else $error("pin53 readback");
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pin53_pad_in = 1'b0;
  logic pin53_gpio_out = 1'b0, pin54_gpio_out = 1'b0, interrupt_line_seven_source = 1'b0, pin54_pad_in = 1'b0;
  logic serial_b_transmit_data = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  wire [2:0] hsize = 3'h2;
  wire interrupt_line_nine_source = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, pin53_gpio_in, pin54_gpio_in, serial_b_dataset_ready_n;
  wire interrupt_line_seven, interrupt_line_nine, pin53_pad_out, pin53_pad_oe;
  wire pin54_pad_out, pin54_pad_oe;
  wire hready = hreadyout;
  int mismatches = 0, checked = 0, cyc = 0;
  gpcfg_top dut (.*);
  initial forever #12.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      complete_run;
    end
  end
  task complete_run;
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // single word transfer; waits on the slave, never on a fixed count
  task xfer(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task cfg(input logic [31:0] a, d);
    xfer(1'b1, a, d);
    repeat (5) @(posedge hclk);
  endtask
  task t_regs;
    xfer(1'b0, 32'h10C, 32'h0);
    chk(r, 32'h01);
    chk({hreadyout, hresp}, 32'h2);
    xfer(1'b1, 32'h10C, 32'hFF);
    xfer(1'b0, 32'h10C, 32'h0);
    chk(r, 32'h8F);
    xfer(1'b1, 32'h200, 32'hFF);
    xfer(1'b0, 32'h200, 32'h0);
    chk(r, 32'h0);
  endtask
  task t_in54;
    pin54_pad_in <= 1'b1;
    cfg(32'h10C, 32'h01);
    chk({pin54_pad_oe, pin54_gpio_in}, 32'h1);
    cfg(32'h10C, 32'h03);
    chk(pin54_gpio_in, 32'h0);
    pin54_pad_in <= 1'b0;
    cfg(32'h10C, 32'h05);
    chk(serial_b_dataset_ready_n, 32'h0);
    cfg(32'h10C, 32'h0B);
    chk({interrupt_line_nine, pin54_pad_oe}, 32'h2);
    pin54_pad_in <= 1'b1;
    cfg(32'h10C, 32'h0D);
    chk(pin54_gpio_in, 32'h1);
    pin54_gpio_out <= 1'b1;
    cfg(32'h10C, 32'h00);
    chk({pin54_pad_oe, pin54_pad_out}, 32'h3);
  endtask
  task t_out53;
    pin53_gpio_out <= 1'b1;
    cfg(32'h108, 32'h00);
    chk({pin53_pad_oe, pin53_pad_out}, 32'h3);
    cfg(32'h108, 32'h80);
    chk(pin53_pad_oe, 32'h0);
    pin53_gpio_out <= 1'b0;
    serial_b_transmit_data <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({pin53_pad_oe, pin53_pad_out}, 32'h2);
    cfg(32'h108, 32'h04);
    chk({pin53_pad_oe, pin53_pad_out}, 32'h3);
    interrupt_line_seven_source <= 1'b1;
    cfg(32'h108, 32'h08);
    chk({pin53_pad_out, interrupt_line_seven}, 32'h3);
    pin53_pad_in <= 1'b1;
    cfg(32'h108, 32'h01);
    chk({pin53_pad_oe, pin53_gpio_in}, 32'h1);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_in54;
    t_out53;
    complete_run;
  end
endmodule
bind gpcfg_top gpcfg_chk u_chk (.*);
`default_nettype wire
